/* File: rtl/afesel_pkg.sv */
// Constants shared by the select-gated serial target and its configuration registers.
package afesel_pkg;

    // ----------------------------------------------------------------
    // Register pointers
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_LOCK     = 8'h01;
    localparam logic [7:0] ADDR_TIA_CTRL = 8'h10;
    localparam logic [7:0] ADDR_REF_CTRL = 8'h11;
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h12;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_STATUS    = 8'h01;
    localparam logic [7:0] RST_LOCK      = 8'h01;
    localparam logic [7:0] RST_TIA_CTRL  = 8'h03;
    localparam logic [7:0] RST_REF_CTRL  = 8'h20;
    localparam logic [7:0] RST_MODE_CTRL = 8'h00;

    // ----------------------------------------------------------------
    // Field layouts and counts
    // ----------------------------------------------------------------
    localparam int          LOCK_BIT     = 0;
    localparam logic [7:0]  TIA_MASK     = 8'h1f;
    localparam logic [7:0]  MODE_MASK    = 8'h87;
    localparam logic [7:0]  LOCK_MASK    = 8'h01;
    localparam logic [2:0]  LAST_BIT     = 3'h7;
    // Arbitrary default target address; the real value is set by the parameter.
    localparam logic [6:0]  DEF_TARGET_ADDR = 7'h2a;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK
    } afesel_state_t;

endpackage

/* File: rtl/afesel_reg_if.sv */
// Register access path between the serial engine and the configuration registers.
`timescale 1ns/1ps
`default_nettype none
interface afesel_reg_if;
    logic       wrStb;
    logic [7:0] ptr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic       abort;

    modport engine (output wrStb, output ptr, output wrData, output abort, input rdData);
    modport regs   (input wrStb, input ptr, input wrData, input abort, output rdData);
endinterface
`default_nettype wire

/* File: rtl/afesel_regs.sv */
// Configuration registers with write protection and registered read data.
`timescale 1ns/1ps
`default_nettype none
module afesel_regs
    import afesel_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Engine side
    afesel_reg_if.regs      bus,
    // Configuration outputs
    output logic [7:0]      tiaCtrl_ff,
    output logic [7:0]      refCtrl_ff,
    output logic [7:0]      modeCtrl_ff
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic [7:0] lock_ff;
    logic [7:0] rdData_ff;
    wire        locked   = lock_ff[LOCK_BIT];
    // A write that races a deselect is dropped so no half-done command lands.
    wire        wrOk     = bus.wrStb & ~bus.abort;                          // see R13
    wire        wrLock   = wrOk && bus.ptr == ADDR_LOCK;
    wire        wrTia    = wrOk && bus.ptr == ADDR_TIA_CTRL && !locked;
    wire        wrRef    = wrOk && bus.ptr == ADDR_REF_CTRL && !locked;
    wire        wrMode   = wrOk && bus.ptr == ADDR_MODE_CTRL;
    logic [7:0] nxt_rdData;

    always_comb begin
        unique case (bus.ptr)
            ADDR_STATUS:    nxt_rdData = RST_STATUS;
            ADDR_LOCK:      nxt_rdData = lock_ff;
            ADDR_TIA_CTRL:  nxt_rdData = tiaCtrl_ff;
            ADDR_REF_CTRL:  nxt_rdData = refCtrl_ff;
            ADDR_MODE_CTRL: nxt_rdData = modeCtrl_ff;
            default:        nxt_rdData = 8'h00;
        endcase
    end

    assign bus.rdData = rdData_ff;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_ff     <= RST_LOCK;
            tiaCtrl_ff  <= RST_TIA_CTRL;
            refCtrl_ff  <= RST_REF_CTRL;
            modeCtrl_ff <= RST_MODE_CTRL;
            rdData_ff   <= 8'h00;
        end else begin
            rdData_ff <= nxt_rdData;
            if (wrLock) lock_ff <= bus.wrData & LOCK_MASK;
            if (wrTia) tiaCtrl_ff <= bus.wrData & TIA_MASK;
            if (wrRef) refCtrl_ff <= bus.wrData;                            // see R09
            if (wrMode) modeCtrl_ff <= bus.wrData & MODE_MASK;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/afesel_target.sv */
// Select-gated two-wire serial target for the sensor front end configuration.
// Operation
// R01 - Fixed target address, set only at build
// R02 - Bus traffic taken only while select low
// R03 - Only the selected device acknowledges
// R04 - Host selects one device at a time
// R05 - Host shares lines, one select each
// R06 - Host loads config registers at startup
// R07 - Host uses EEPROM addresses with pin zero
// R08 - One part per module acknowledges
// R09 - Host written bias drives bias path
// R10 - Host restores configuration after health test
// R11 - Host may deep sleep with shorting
// R12 - Single device may tie select low
// R13 - Deselected: data released, partial transaction dropped
`timescale 1ns/1ps
`default_nettype none
module afesel_target
    import afesel_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = DEF_TARGET_ADDR
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Serial bus pins
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // Module select, active low
    input  wire logic       busSelect_b,
    // Configuration outputs
    output logic [7:0]      tiaCtrl,
    output logic [7:0]      refCtrl,
    output logic [7:0]      modeCtrl
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sclSync_ff;
    logic [1:0] sdaSync_ff;
    logic [1:0] selSync_ff;
    logic       sclPrev_ff;
    logic       sdaPrev_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclSync_ff <= 2'h3;
            sdaSync_ff <= 2'h3;
            selSync_ff <= 2'h3;
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end else begin
            sclSync_ff <= {sclSync_ff[0], sclIn};
            sdaSync_ff <= {sdaSync_ff[0], sdaIn};
            selSync_ff <= {selSync_ff[0], busSelect_b};
            sclPrev_ff <= sclSync_ff[1];
            sdaPrev_ff <= sdaSync_ff[1];
        end
    end

    wire scl      = sclSync_ff[1];
    wire sda      = sdaSync_ff[1];
    wire selected = ~selSync_ff[1];                                         // see R02
    wire sclRise  = scl & ~sclPrev_ff;
    wire sclFall  = ~scl & sclPrev_ff;
    wire startEv  = scl & sclPrev_ff & sdaPrev_ff & ~sda;
    wire stopEv   = scl & sclPrev_ff & ~sdaPrev_ff & sda;

    // ----------------------------------------------------------------
    // Engine state
    // ----------------------------------------------------------------
    afesel_state_t state_ff;
    afesel_state_t nxt_state;
    afesel_state_t after_ff;
    afesel_state_t nxt_after;
    logic [2:0]    bitCnt_ff;
    logic [2:0]    nxt_bitCnt;
    logic [7:0]    shift_ff;
    logic [7:0]    nxt_shift;
    logic          rxFull_ff;
    logic          nxt_rxFull;
    logic          oe_ff;
    logic          nxt_oe;
    logic [7:0]    ptr_ff;
    logic [7:0]    nxt_ptr;
    logic          wrStb_ff;
    logic          nxt_wrStb;

    afesel_reg_if regBus ();

    assign regBus.wrStb  = wrStb_ff;
    assign regBus.ptr    = ptr_ff;
    assign regBus.wrData = shift_ff;
    assign regBus.abort  = ~selected;

    wire addrMatch = shift_ff[7:1] == TARGET_ADDR;                          // see R01
    wire byteDone  = bitCnt_ff == LAST_BIT;

    // ----------------------------------------------------------------
    // Next-state decode
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state  = state_ff;
        nxt_after  = after_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_shift  = shift_ff;
        nxt_rxFull = rxFull_ff;
        nxt_oe     = oe_ff;
        nxt_ptr    = ptr_ff;
        nxt_wrStb  = 1'b0;
        if (!selected) begin
            // Releasing the line and forgetting the partial byte here keeps a
            // deselect in mid-frame from leaving the bus stuck low.
            nxt_state  = ST_IDLE;                                           // see R13
            nxt_oe     = 1'b0;                                              // see R13
            nxt_rxFull = 1'b0;
        end else if (startEv) begin
            nxt_state  = ST_ADDR;
            nxt_bitCnt = 3'h0;
            nxt_rxFull = 1'b0;
            nxt_oe     = 1'b0;
        end else if (stopEv) begin
            nxt_state  = ST_IDLE;
            nxt_oe     = 1'b0;
        end else if (sclRise) begin
            unique case (state_ff)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    nxt_shift  = {shift_ff[6:0], sda};
                    nxt_bitCnt = bitCnt_ff + 3'h1;
                    nxt_rxFull = byteDone;
                end
                ST_RDATA: begin
                    nxt_bitCnt = bitCnt_ff + 3'h1;
                    if (byteDone) nxt_state = ST_RACK;
                end
                ST_RACK: begin
                    // A not-acknowledge from the host ends the read burst.
                    nxt_state = sda ? ST_IDLE : ST_RDATA;
                end
                default: ;
            endcase
        end else if (sclFall) begin
            unique case (state_ff)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (rxFull_ff) begin
                        nxt_rxFull = 1'b0;
                        nxt_oe     = 1'b1;
                        nxt_state  = ST_ACK;
                        if (state_ff == ST_ADDR) begin
                            nxt_oe    = addrMatch;                          // see R03, R08
                            nxt_state = addrMatch ? ST_ACK : ST_IDLE;
                            nxt_after = shift_ff[0] ? ST_RDATA : ST_PTR;
                        end else if (state_ff == ST_PTR) begin
                            nxt_ptr   = shift_ff;
                            nxt_after = ST_WDATA;
                        end else begin
                            nxt_wrStb = 1'b1;
                            nxt_after = ST_WDATA;
                        end
                    end
                end
                ST_ACK: begin
                    nxt_state  = after_ff;
                    nxt_bitCnt = 3'h0;
                    nxt_shift  = regBus.rdData;
                    nxt_oe     = after_ff == ST_RDATA && !regBus.rdData[7];
                end
                ST_RDATA: begin
                    nxt_shift = {shift_ff[6:0], 1'b0};
                    nxt_oe    = !shift_ff[6];
                end
                ST_RACK: begin
                    nxt_oe = 1'b0;
                end
                default: begin
                    // Idle: nothing to send, so the data line stays released.
                    nxt_oe = 1'b0;
                end
            endcase
            if (state_ff == ST_IDLE) nxt_oe = 1'b0;
        end
        if (sclFall && state_ff == ST_RDATA && bitCnt_ff == 3'h0 && after_ff == ST_RACK) begin
            nxt_oe = oe_ff;
        end
    end

    // ----------------------------------------------------------------
    // Read restart after host acknowledge
    // ----------------------------------------------------------------
    // Leaving the acknowledge slot, the next byte is reloaded on the fall.
    logic rdFresh_ff;
    wire  reloadRd = sclFall && state_ff == ST_RDATA && bitCnt_ff == 3'h0 && rdFresh_ff;
    wire  nxt_rdFresh = (sclRise && state_ff == ST_RACK && !sda) ? 1'b1
                      : (sclFall ? 1'b0 : rdFresh_ff);

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff   <= ST_IDLE;
            after_ff   <= ST_IDLE;
            bitCnt_ff  <= 3'h0;
            shift_ff   <= 8'h00;
            rxFull_ff  <= 1'b0;
            oe_ff      <= 1'b0;
            ptr_ff     <= 8'h00;
            wrStb_ff   <= 1'b0;
            rdFresh_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            after_ff   <= nxt_after;
            bitCnt_ff  <= nxt_bitCnt;
            shift_ff   <= reloadRd ? regBus.rdData : nxt_shift;
            rxFull_ff  <= nxt_rxFull;
            oe_ff      <= reloadRd ? (selected & ~regBus.rdData[7]) : nxt_oe;
            ptr_ff     <= nxt_ptr;
            wrStb_ff   <= nxt_wrStb;
            rdFresh_ff <= nxt_rdFresh;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic sdaOut_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sdaOut_ff <= 1'b0;
        end else begin
            sdaOut_ff <= 1'b0;
        end
    end

    assign sdaOut = sdaOut_ff;
    assign sdaOe  = oe_ff;                                                  // see R13

    afesel_regs u_regs (
        .clk         (clk),
        .rst_b       (rst_b),
        .bus         (regBus),
        .tiaCtrl_ff  (tiaCtrl),
        .refCtrl_ff  (refCtrl),
        .modeCtrl_ff (modeCtrl)
    );

endmodule
`default_nettype wire

/* File: bench/afesel_target_asserts.sv */
// Concurrent checks on the ports of the select-gated serial target.
`timescale 1ns/1ps
`default_nettype none
module afesel_target_asserts
    import afesel_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = DEF_TARGET_ADDR
)
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // Serial bus pins
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       busSelect_b,
    // Configuration outputs
    input wire logic [7:0] tiaCtrl,
    input wire logic [7:0] refCtrl,
    input wire logic [7:0] modeCtrl
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Select high long enough to pass the synchronisers.
    sequence sDeselHeld;
        busSelect_b [*4];
    endsequence
    // Clock high while selected, well past any drive change.
    sequence sSelClkHigh;
        (sclIn && !busSelect_b) [*4];
    endsequence

    AST_SDA_OPEN_DRAIN: assert property (sdaOut == 1'b0)
        else $error("data line driven high");
    AST_DESEL_SILENT: assert property (sDeselHeld |-> !sdaOe)
        else $error("deselected target pulls data line");
    AST_DRIVE_HOLDS_HIGH: assert property (sSelClkHigh |-> $stable(sdaOe))
        else $error("data drive changed while clock high");
    AST_ACK_SLOT: assert property ($rose(sdaOe) |-> sdaOe [*6])
        else $error("data drive shorter than a bit slot");
    AST_CFG_SELECTED: assert property (
        !$stable({tiaCtrl, refCtrl, modeCtrl}) |-> !busSelect_b)
        else $error("configuration changed while deselected");
    AST_RESERVED_ZERO: assert property (
        tiaCtrl[7:5] == 3'h0 && modeCtrl[6:3] == 4'h0)
        else $error("reserved configuration bits set");
    AST_RESET_VALUES: assert property ($rose(rst_b) |->
        tiaCtrl == RST_TIA_CTRL && refCtrl == RST_REF_CTRL && modeCtrl == RST_MODE_CTRL
        && !sdaOe)
        else $error("outputs not at reset values");
endmodule

bind afesel_target afesel_target_asserts #(.TARGET_ADDR(TARGET_ADDR)) u_asserts (
    .clk(clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .busSelect_b(busSelect_b), .tiaCtrl(tiaCtrl), .refCtrl(refCtrl),
    .modeCtrl(modeCtrl));
`default_nettype wire

/* File: bench/afesel_host.sv */
// Host controller model driving the shared two-wire bus and the module selects.
`timescale 1ns/1ps
`default_nettype none
module afesel_host (
    // Clock
    input  wire logic  clk,
    // Shared bus, one data and one clock line for all modules
    input  wire logic  sdaWire,
    output logic       sclOut,
    output logic       sdaOe,
    // Module selects, active low, one output each
    output logic [1:0] select_b
);
    initial begin
        sclOut = 1'b1;
        sdaOe = 1'b0;
        select_b = 2'b11;
    end

    task automatic waitClk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Data set mid-low and sampled mid-high, so the target's synchronisers settle.
    task automatic bitSlot(input logic b, output logic seen);
        sclOut = 1'b0;
        waitClk(2);
        sdaOe = !b;
        waitClk(2);
        sclOut = 1'b1;
        waitClk(2);
        seen = sdaWire;
        waitClk(2);
    endtask

    // Also serves as repeated start; the extra low phase lets an ACK release first.
    task automatic busStart();
        sclOut = 1'b0;
        waitClk(3);
        sdaOe = 1'b0;
        waitClk(3);
        sclOut = 1'b1;
        waitClk(2);
        sdaOe = 1'b1;
        waitClk(2);
    endtask

    task automatic busStop();
        sclOut = 1'b0;
        waitClk(2);
        sdaOe = 1'b1;
        waitClk(2);
        sclOut = 1'b1;
        waitClk(2);
        sdaOe = 1'b0;
        waitClk(2);
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitSlot(b[i], s);
        end
        bitSlot(1'b1, s);
        ack = !s;
    endtask

    // Only one select low at a time, raised again after the exchange.
    // A lone device could keep its select tied low; this model raises it again after every exchange.
    // The select also drives the EEPROM address pin, so only pin-zero EEPROM
    // addresses belong to a selected module; this bench has no EEPROM and sends no EEPROM address.
    task automatic selectDev(input int dev);
        select_b = ~2'(1 << dev);
        waitClk(4);
    endtask

    // With cut set, the data byte is broken off after four bits by deselecting.
    task automatic writeReg(input int dev, input logic [6:0] addr, input logic [7:0] ptr,
                            input logic [7:0] d, input logic cut, output logic ok);
        logic a0, a1, a2, s;
        selectDev(dev);
        busStart();
        sendByte({addr, 1'b0}, a0);
        sendByte(ptr, a1);
        a2 = 1'b1;
        if (cut) begin
            for (int i = 7; i > 3; i--) begin
                bitSlot(d[i], s);
            end
            select_b = 2'b11;
            waitClk(8);
        end else begin
            sendByte(d, a2);
        end
        busStop();
        select_b = 2'b11;
        waitClk(4);
        ok = a0 & a1 & a2;
    endtask

    task automatic readReg(input int dev, input logic [6:0] addr, input logic [7:0] ptr,
                           output logic [7:0] d, output logic [7:0] d2, output logic ok);
        logic a0, a1, a2, s;
        selectDev(dev);
        busStart();
        sendByte({addr, 1'b0}, a0);
        sendByte(ptr, a1);
        busStart();
        sendByte({addr, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) begin
            bitSlot(1'b1, d[i]);
        end
        // Host acknowledge asks for the same register once more.
        bitSlot(1'b0, s);
        for (int i = 7; i >= 0; i--) begin
            bitSlot(1'b1, d2[i]);
        end
        bitSlot(1'b1, s);
        busStop();
        select_b = 2'b11;
        waitClk(4);
        ok = a0 & a1 & a2;
    endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench: two targets on one bus behind one host model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import afesel_pkg::*;
    localparam logic [6:0] ADDR = 7'h2a;
    typedef struct {logic [7:0] ptr; logic [7:0] data; logic [7:0] want;} afesel_row_t;

    logic       clk, rst_b, sclOut, hostOe, oeA, oeB, ok;
    logic [1:0] select_b;
    logic [7:0] tiaA, refA, modeA, tiaB, refB, modeB, rd, rd2;
    int         mismatches = 0;
    int         checks = 0;
    // Pull-up: the line is low only while some party pulls it.
    wire        sdaWire = !(hostOe || oeA || oeB);

    // Startup load, bias steps and restore, sleep with shorting, odd pointers.
    afesel_row_t rows [8] = '{
        '{8'h01, 8'h00, 8'h00}, '{8'h10, 8'hff, 8'h1f},
        '{8'h11, 8'h14, 8'h14}, '{8'h11, 8'h20, 8'h20},
        '{8'h12, 8'hff, 8'h87}, '{8'h12, 8'h80, 8'h80},
        '{8'h05, 8'h55, 8'h00}, '{8'h00, 8'h00, 8'h01}};

    afesel_host host (.clk(clk), .sdaWire(sdaWire), .sclOut(sclOut), .sdaOe(hostOe),
                      .select_b(select_b));
    afesel_target #(.TARGET_ADDR(ADDR)) dut (.clk(clk), .rst_b(rst_b), .sclIn(sclOut),
        .sdaIn(sdaWire), .sdaOut(), .sdaOe(oeA), .busSelect_b(select_b[0]),
        .tiaCtrl(tiaA), .refCtrl(refA), .modeCtrl(modeA));
    afesel_target #(.TARGET_ADDR(ADDR)) dutPeer (.clk(clk), .rst_b(rst_b), .sclIn(sclOut),
        .sdaIn(sdaWire), .sdaOut(), .sdaOe(oeB), .busSelect_b(select_b[1]),
        .tiaCtrl(tiaB), .refCtrl(refB), .modeCtrl(modeB));

    always #25 clk = ~clk;

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        foreach (rows[i]) begin
            host.writeReg(0, ADDR, rows[i].ptr, rows[i].data, 1'b0, ok);
            chk("write ack", {7'h00, ok}, 8'h01);
            if (rows[i].ptr == 8'h11) chk("bias port", refA, rows[i].want);
            if (rows[i].ptr == 8'h10) chk("tia port", tiaA, rows[i].want);
            host.readReg(0, ADDR, rows[i].ptr, rd, rd2, ok);
            chk("read ack", {7'h00, ok}, 8'h01);
            chk("read data", rd, rows[i].want);
            chk("read repeat", rd2, rows[i].want);
        end
        chk("bias path", refA, 8'h20);
        chk("mode", modeA, 8'h80);
        chk("peer tia", tiaB, RST_TIA_CTRL);
        host.writeReg(0, ADDR ^ 7'h01, 8'h11, 8'h33, 1'b0, ok);
        chk("foreign address ack", {7'h00, ok}, 8'h00);
        host.writeReg(2, ADDR, 8'h11, 8'h33, 1'b0, ok);
        chk("unselected ack", {7'h00, ok}, 8'h00);
        chk("unselected bias", refA, 8'h20);
        host.writeReg(1, ADDR, 8'h12, 8'h03, 1'b0, ok);
        chk("peer mode", modeB, 8'h03);
        chk("idle mode", modeA, 8'h80);
        host.writeReg(0, ADDR, 8'h12, 8'h01, 1'b1, ok);
        chk("aborted mode", modeA, 8'h80);
        host.writeReg(0, ADDR, 8'h12, 8'h02, 1'b0, ok);
        chk("after abort", modeA, 8'h02);
        host.writeReg(0, ADDR, 8'h01, 8'h01, 1'b0, ok);
        host.writeReg(0, ADDR, 8'h11, 8'h05, 1'b0, ok);
        chk("locked ack", {7'h00, ok}, 8'h01);
        chk("locked bias", refA, 8'h20);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        chk("reset tia", tiaA, RST_TIA_CTRL);
        chk("reset mode", modeA, RST_MODE_CTRL);
        chk("reset peer", modeB, RST_MODE_CTRL);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        end_of_test();
    end
endmodule
`default_nettype wire
